// ==== cpg_pkg.sv ====
package cpg_pkg;

    // ----------------------------------------
    // main register space, indirect access
    // ----------------------------------------
    localparam logic [7:0] CPG_ADDR_PAGE     = 8'hb0;
    localparam logic [7:0] CPG_ADDR_OFFSET   = 8'hb1;
    localparam logic [7:0] CPG_ADDR_DATA     = 8'hb2;
    localparam logic [7:0] CPG_PAGE_GEN      = 8'h00;
    localparam logic [7:0] CPG_PAGE_RESET    = 8'h00;
    localparam logic [7:0] CPG_OFFSET_RESET  = 8'h00;

    // ----------------------------------------
    // generator page offsets
    // ----------------------------------------
    localparam logic [7:0] CPG_OFF_CONTROL   = 8'h01;
    localparam logic [7:0] CPG_OFF_CONFIG    = 8'h02;
    localparam logic [7:0] CPG_OFF_DATA_ID   = 8'h03;
    localparam logic [7:0] CPG_OFF_LLEN_HI   = 8'h04;
    localparam logic [7:0] CPG_OFF_LLEN_LO   = 8'h05;
    localparam logic [7:0] CPG_OFF_BAR_HI    = 8'h06;
    localparam logic [7:0] CPG_OFF_BAR_LO    = 8'h07;
    localparam logic [7:0] CPG_OFF_ACT_HI    = 8'h08;
    localparam logic [7:0] CPG_OFF_ACT_LO    = 8'h09;
    localparam logic [7:0] CPG_OFF_TOT_HI    = 8'h0a;
    localparam logic [7:0] CPG_OFF_TOT_LO    = 8'h0b;
    localparam logic [7:0] CPG_OFF_PER_HI    = 8'h0c;
    localparam logic [7:0] CPG_OFF_PER_LO    = 8'h0d;
    localparam logic [7:0] CPG_OFF_BACK      = 8'h0e;
    localparam logic [7:0] CPG_OFF_FRONT     = 8'h0f;
    localparam logic [7:0] CPG_OFF_BLOCK0    = 8'h10;
    localparam logic [7:0] CPG_OFF_LAST_RW   = 8'h1f;
    localparam logic [7:0] CPG_OFF_STATUS    = 8'h20;
    localparam int         CPG_NUM_REGS      = 32;
    localparam logic [7:0] CPG_REG_RESET     = 8'h00;

    // ----------------------------------------
    // field positions
    // ----------------------------------------
    localparam int CPG_CTL_ENABLE_BIT  = 0;
    localparam int CPG_CFG_BARS_LSB    = 0;
    localparam int CPG_CFG_FIXED_BIT   = 3;
    localparam int CPG_CFG_BLEN_LSB    = 4;
    localparam int CPG_BLOCK_BYTES     = 16;

    // ----------------------------------------
    // pattern and timing
    // ----------------------------------------
    localparam logic [63:0] CPG_BAR_VALUES = 64'h800f_cc55_7ff0_33aa;
    localparam logic [1:0]  CPG_SELFTEST_OUT_ON = 2'b10;
    localparam int CPG_CLK_NS       = 20;
    localparam int CPG_UNIT_NS      = 10;
    localparam int CPG_UNIT_SLOW_NS = 20;
    localparam logic [16:0] CPG_STEP_FAST = 17'(CPG_CLK_NS / CPG_UNIT_NS);
    localparam logic [16:0] CPG_STEP_SLOW = 17'(CPG_CLK_NS / CPG_UNIT_SLOW_NS);

    typedef enum logic [1:0] {
        CPG_PKT_FRAME_START = 2'b00,
        CPG_PKT_FRAME_END   = 2'b01,
        CPG_PKT_LONG_HEADER = 2'b10,
        CPG_PKT_PAYLOAD     = 2'b11
    } cpg_kind_t;

    typedef struct packed {
        cpg_kind_t   kind;
        logic [7:0]  data_id;
        logic [15:0] word_count;
        logic [7:0]  data;
        logic        last;
    } cpg_tx_t;

    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } cpg_reg_req_t;

endpackage : cpg_pkg

// ==== cpg_pattern_source.sv ====
`timescale 1ns/1ps
`default_nettype none
module cpg_pattern_source (
    input  wire logic         clock,
    input  wire logic         reset_n,
    input  wire logic         restart,
    input  wire logic         advance,
    input  wire logic         fixed_mode,
    input  wire logic [1:0]   bar_code,
    input  wire logic [15:0]  bar_width,
    input  wire logic [3:0]   block_last,
    input  wire logic [127:0] block_bytes,
    output logic [7:0]        pattern_byte
);
    import cpg_pkg::*;

    // ----------------------------------------
    // position state
    // ----------------------------------------
    logic [2:0]  bar_reg,  bar_next;
    logic [15:0] cnt_reg,  cnt_next;
    logic [3:0]  blk_reg,  blk_next;
    logic [2:0]  bar_last;
    logic [7:0]  invert;

    assign bar_last = 3'((4'h1 << bar_code) - 4'h1);
    assign invert   = bar_reg[0] ? 8'hff : 8'h00;

    always_comb begin
        if (fixed_mode) begin
            pattern_byte = block_bytes[blk_reg*8 +: 8] ^ invert;
        end else begin
            pattern_byte = CPG_BAR_VALUES[bar_reg*8 +: 8];
        end
    end

    always_comb begin
        bar_next = bar_reg;
        cnt_next = cnt_reg;
        blk_next = blk_reg;
        if (restart) begin
            bar_next = 3'h0;
            cnt_next = 16'h0000;
            blk_next = 4'h0;
        end else if (advance) begin
            blk_next = (blk_reg == block_last) ? 4'h0 : blk_reg + 4'h1;
            if (bar_reg == bar_last) begin
                cnt_next = cnt_reg;
            end else if (cnt_reg + 16'h0001 == bar_width) begin
                cnt_next = 16'h0000;
                bar_next = bar_reg + 3'h1;
            end else begin
                cnt_next = cnt_reg + 16'h0001;
            end
        end
    end

    always_ff @(posedge clock) begin
        if (!reset_n) begin
            bar_reg <= 3'h0;
            cnt_reg <= 16'h0000;
            blk_reg <= 4'h0;
        end else begin
            bar_reg <= bar_next;
            cnt_reg <= cnt_next;
            blk_reg <= blk_next;
        end
    end

endmodule : cpg_pattern_source
`default_nettype wire

// ==== cpg_generator.sv ====
`timescale 1ns/1ps
`default_nettype none
module cpg_generator (
    input  wire logic                  clock,
    input  wire logic                  reset_n,
    input  wire cpg_pkg::cpg_reg_req_t reg_req,
    output logic [7:0]                 reg_rdata,
    input  wire logic                  rate_400,
    input  wire logic                  selftest_active,
    input  wire logic [1:0]            selftest_output_gating,
    output cpg_pkg::cpg_tx_t           tx_data,
    output logic                       tx_valid,
    input  wire logic                  tx_ready,
    output logic                       lanes_idle_lp11,
    output logic                       lanes_disabled
);
    import cpg_pkg::*;

    // ----------------------------------------
    // register file
    // ----------------------------------------
    logic [7:0]   page_reg,  page_next;
    logic [7:0]   off_reg,   off_next;
    logic [7:0]   rdata_reg, rdata_next;
    logic [7:0]   ind_reg  [CPG_NUM_REGS];
    logic [7:0]   ind_next [CPG_NUM_REGS];
    logic [7:0]   status;
    logic [127:0] block_bytes;

    logic         gen_enable;
    logic         fixed_mode;
    logic [1:0]   bar_code;
    logic [3:0]   block_last;
    logic [7:0]   data_id;
    logic [15:0]  line_len;
    logic [15:0]  bar_width;
    logic [15:0]  act_lines;
    logic [15:0]  tot_lines;
    logic [15:0]  period_units;
    logic [7:0]   back_porch_count;
    logic [7:0]   front_porch_count;

    assign gen_enable        = ind_reg[CPG_OFF_CONTROL[4:0]][CPG_CTL_ENABLE_BIT];
    assign fixed_mode        = ind_reg[CPG_OFF_CONFIG[4:0]][CPG_CFG_FIXED_BIT];
    assign bar_code          = ind_reg[CPG_OFF_CONFIG[4:0]][CPG_CFG_BARS_LSB +: 2];
    assign block_last        = ind_reg[CPG_OFF_CONFIG[4:0]][CPG_CFG_BLEN_LSB +: 4];
    assign data_id           = ind_reg[CPG_OFF_DATA_ID[4:0]];
    assign line_len          = {ind_reg[CPG_OFF_LLEN_HI[4:0]], ind_reg[CPG_OFF_LLEN_LO[4:0]]};
    assign bar_width         = {ind_reg[CPG_OFF_BAR_HI[4:0]], ind_reg[CPG_OFF_BAR_LO[4:0]]};
    assign act_lines         = {ind_reg[CPG_OFF_ACT_HI[4:0]], ind_reg[CPG_OFF_ACT_LO[4:0]]};
    assign tot_lines         = {ind_reg[CPG_OFF_TOT_HI[4:0]], ind_reg[CPG_OFF_TOT_LO[4:0]]};
    assign period_units      = {ind_reg[CPG_OFF_PER_HI[4:0]], ind_reg[CPG_OFF_PER_LO[4:0]]};
    assign back_porch_count  = ind_reg[CPG_OFF_BACK[4:0]];
    assign front_porch_count = ind_reg[CPG_OFF_FRONT[4:0]];

    genvar gi;
    generate
        for (gi = 0; gi < CPG_BLOCK_BYTES; gi++) begin : g_block
            assign block_bytes[gi*8 +: 8] = ind_reg[CPG_OFF_BLOCK0[4:0] + 5'(gi)];
        end
    endgenerate

    always_comb begin
        page_next  = page_reg;
        off_next   = off_reg;
        rdata_next = rdata_reg;
        for (int i = 0; i < CPG_NUM_REGS; i++) begin
            ind_next[i] = ind_reg[i];
        end
        if (reg_req.wr) begin
            unique case (reg_req.addr)
                CPG_ADDR_PAGE:   page_next = reg_req.wdata;
                CPG_ADDR_OFFSET: off_next  = reg_req.wdata;
                CPG_ADDR_DATA: begin
                    if (page_reg == CPG_PAGE_GEN && off_reg >= CPG_OFF_CONTROL
                        && off_reg <= CPG_OFF_LAST_RW) begin
                        ind_next[off_reg[4:0]] = reg_req.wdata;
                    end
                end
                default: ;
            endcase
        end
        if (reg_req.rd) begin
            unique case (reg_req.addr)
                CPG_ADDR_PAGE:   rdata_next = page_reg;
                CPG_ADDR_OFFSET: rdata_next = off_reg;
                CPG_ADDR_DATA: begin
                    if (page_reg != CPG_PAGE_GEN) begin
                        rdata_next = 8'h00;
                    end else if (off_reg == CPG_OFF_STATUS) begin
                        rdata_next = status;
                    end else if (off_reg <= CPG_OFF_LAST_RW) begin
                        rdata_next = ind_reg[off_reg[4:0]];
                    end else begin
                        rdata_next = 8'h00;
                    end
                end
                default: rdata_next = 8'h00;
            endcase
        end
    end

    always_ff @(posedge clock) begin
        if (!reset_n) begin
            page_reg  <= CPG_PAGE_RESET;
            off_reg   <= CPG_OFFSET_RESET;
            rdata_reg <= 8'h00;
            for (int i = 0; i < CPG_NUM_REGS; i++) begin
                ind_reg[i] <= CPG_REG_RESET;
            end
        end else begin
            page_reg  <= page_next;
            off_reg   <= off_next;
            rdata_reg <= rdata_next;
            for (int i = 0; i < CPG_NUM_REGS; i++) begin
                ind_reg[i] <= ind_next[i];
            end
        end
    end

    assign reg_rdata = rdata_reg;

    // ----------------------------------------
    // frame sequencer
    // ----------------------------------------
    typedef enum logic [2:0] {
        ST_IDLE        = 3'b000,
        ST_FRAME_START = 3'b001,
        ST_LINE_BODY   = 3'b010,
        ST_HEADER      = 3'b011,
        ST_PAYLOAD     = 3'b100,
        ST_FRAME_END   = 3'b101,
        ST_LINE_WAIT   = 3'b110
    } cpg_state_t;

    cpg_state_t  state_reg, state_next;
    logic [15:0] line_reg,  line_next;
    logic [15:0] byte_reg,  byte_next;
    logic [16:0] tim_reg,   tim_next;
    cpg_tx_t     tx_reg,    tx_next;
    logic        valid_reg, valid_next;

    logic        load;
    logic [16:0] step;
    logic        period_done;
    logic [16:0] act_start;
    logic [16:0] act_end;
    logic [16:0] fe_line;
    logic        line_active;
    logic        src_restart;
    logic        src_advance;
    logic [7:0]  src_byte;

    assign load        = !valid_reg || tx_ready;
    assign step        = rate_400 ? CPG_STEP_SLOW : CPG_STEP_FAST;
    assign period_done = (tim_reg + step) >= {1'b0, period_units};
    assign act_start   = {9'h000, back_porch_count};
    assign act_end     = act_start + {1'b0, act_lines};
    assign fe_line     = act_end + {9'h000, front_porch_count};
    assign line_active = ({1'b0, line_reg} >= act_start) && ({1'b0, line_reg} < act_end);
    assign status      = {6'h00, line_active && state_reg != ST_IDLE, state_reg != ST_IDLE};

    always_comb begin
        state_next  = state_reg;
        line_next   = line_reg;
        byte_next   = byte_reg;
        tx_next     = tx_reg;
        valid_next  = load ? 1'b0 : valid_reg;
        src_restart = 1'b0;
        src_advance = 1'b0;
        if (state_reg == ST_IDLE) begin
            tim_next = 17'h00000;
        end else if (period_done) begin
            tim_next = tim_reg;
        end else begin
            tim_next = tim_reg + step;
        end
        unique case (state_reg)
            ST_IDLE: begin
                if (gen_enable) begin
                    state_next = ST_FRAME_START;
                    line_next  = 16'h0000;
                end
            end
            ST_FRAME_START: begin
                if (load) begin
                    tx_next    = '{CPG_PKT_FRAME_START, data_id, 16'h0000, 8'h00, 1'b1};
                    valid_next = 1'b1;
                    state_next = ST_LINE_BODY;
                end
            end
            ST_LINE_BODY: begin
                if (line_active) begin
                    state_next = ST_HEADER;
                end else if ({1'b0, line_reg} == fe_line) begin
                    state_next = ST_FRAME_END;
                end else begin
                    state_next = ST_LINE_WAIT;
                end
            end
            ST_HEADER: begin
                if (load) begin
                    tx_next     = '{CPG_PKT_LONG_HEADER, data_id, line_len, 8'h00, 1'b0};
                    valid_next  = 1'b1;
                    byte_next   = 16'h0000;
                    src_restart = 1'b1;
                    state_next  = (line_len == 16'h0000) ? ST_LINE_WAIT : ST_PAYLOAD;
                end
            end
            ST_PAYLOAD: begin
                if (load) begin
                    tx_next     = '{CPG_PKT_PAYLOAD, data_id, line_len, src_byte,
                                    byte_reg == line_len - 16'h0001};
                    valid_next  = 1'b1;
                    src_advance = 1'b1;
                    byte_next   = byte_reg + 16'h0001;
                    if (byte_reg == line_len - 16'h0001) begin
                        state_next = ST_LINE_WAIT;
                    end
                end
            end
            ST_FRAME_END: begin
                if (load) begin
                    tx_next    = '{CPG_PKT_FRAME_END, data_id, 16'h0000, 8'h00, 1'b1};
                    valid_next = 1'b1;
                    state_next = ST_LINE_WAIT;
                end
            end
            ST_LINE_WAIT: begin
                if (period_done) begin
                    tim_next = 17'h00000;
                    if ({1'b0, line_reg} + 17'h00001 >= {1'b0, tot_lines}) begin
                        line_next  = 16'h0000;
                        state_next = gen_enable ? ST_FRAME_START : ST_IDLE;
                    end else begin
                        line_next  = line_reg + 16'h0001;
                        state_next = ST_LINE_BODY;
                    end
                end
            end
            default: state_next = ST_IDLE;
        endcase
    end

    always_ff @(posedge clock) begin
        if (!reset_n) begin
            state_reg <= ST_IDLE;
            line_reg  <= 16'h0000;
            byte_reg  <= 16'h0000;
            tim_reg   <= 17'h00000;
            tx_reg    <= '0;
            valid_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            line_reg  <= line_next;
            byte_reg  <= byte_next;
            tim_reg   <= tim_next;
            tx_reg    <= tx_next;
            valid_reg <= valid_next;
        end
    end

    // ----------------------------------------
    // pattern bytes
    // ----------------------------------------
    cpg_pattern_source u_source (
        .clock        (clock),
        .reset_n      (reset_n),
        .restart      (src_restart),
        .advance      (src_advance),
        .fixed_mode   (fixed_mode),
        .bar_code     (bar_code),
        .bar_width    (bar_width),
        .block_last   (block_last),
        .block_bytes  (block_bytes),
        .pattern_byte (src_byte)
    );

    // ----------------------------------------
    // transmitter side
    // ----------------------------------------
    assign tx_data         = tx_reg;
    assign tx_valid        = valid_reg;
    assign lanes_idle_lp11 = selftest_active && selftest_output_gating == CPG_SELFTEST_OUT_ON
                             && !gen_enable;
    assign lanes_disabled  = selftest_active && selftest_output_gating != CPG_SELFTEST_OUT_ON;

endmodule : cpg_generator
`default_nettype wire

// ==== cpg_generator_sva.sv ====
`timescale 1ns/1ps
`default_nettype none
module cpg_generator_sva (
    input  wire logic                  clock,
    input  wire logic                  reset_n,
    input  wire cpg_pkg::cpg_reg_req_t reg_req,
    input  wire logic [7:0]            reg_rdata,
    input  wire logic                  selftest_active,
    input  wire logic [1:0]            selftest_output_gating,
    input  wire cpg_pkg::cpg_tx_t      tx_data,
    input  wire logic                  tx_valid,
    input  wire logic                  tx_ready,
    input  wire logic                  lanes_idle_lp11,
    input  wire logic                  lanes_disabled
);
    import cpg_pkg::*;
    // ----------------------------------------
    // payload bytes left in the line, frame open
    // ----------------------------------------
    logic        xfer;
    logic [15:0] rem_reg, rem_next;
    logic        frm_reg, frm_next;
    assign xfer = tx_valid && tx_ready;
    always_comb begin
        rem_next = rem_reg;
        frm_next = frm_reg;
        if (xfer && tx_data.kind == CPG_PKT_LONG_HEADER) rem_next = tx_data.word_count;
        if (xfer && tx_data.kind == CPG_PKT_PAYLOAD && rem_reg != 16'h0000) rem_next = rem_reg - 16'h0001;
        if (xfer && tx_data.kind == CPG_PKT_FRAME_START) frm_next = 1'b1;
        if (xfer && tx_data.kind == CPG_PKT_FRAME_END) frm_next = 1'b0;
    end
    always_ff @(posedge clock) begin
        rem_reg <= reset_n ? rem_next : 16'h0000;
        frm_reg <= reset_n && frm_next;
    end
    // ----------------------------------------
    // assertions
    // ----------------------------------------
    default clocking @(posedge clock); endclocking
    default disable iff (!reset_n);
    a_data_held: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_data))
        else $error("stalled item changed");
    a_payload_count: assert property (xfer && tx_data.kind == CPG_PKT_PAYLOAD |-> rem_reg != 16'h0000)
        else $error("payload beyond line length");
    a_last_flag: assert property (xfer && tx_data.kind == CPG_PKT_PAYLOAD
        |-> tx_data.last == (rem_reg == 16'h0001))
        else $error("last flag misplaced");
    a_line_whole: assert property (xfer && tx_data.kind != CPG_PKT_PAYLOAD |-> rem_reg == 16'h0000)
        else $error("line cut short");
    a_frame_start: assert property (xfer && tx_data.kind == CPG_PKT_FRAME_START |-> !frm_reg)
        else $error("frame start inside frame");
    a_frame_end: assert property (xfer && tx_data.kind == CPG_PKT_FRAME_END |-> frm_reg)
        else $error("frame end outside frame");
    a_line_in_frame: assert property (xfer && tx_data.kind == CPG_PKT_LONG_HEADER |-> frm_reg)
        else $error("line outside frame");
    a_out_gated: assert property (selftest_active && selftest_output_gating != 2'b10
        |-> lanes_disabled && !lanes_idle_lp11)
        else $error("outputs not gated off");
    a_out_free: assert property (!selftest_active |-> !lanes_disabled && !lanes_idle_lp11)
        else $error("lanes gated outside self-test");
    a_read_hold: assert property (!reg_req.rd |=> $stable(reg_rdata))
        else $error("read data changed without read");
    a_bad_addr: assert property (reg_req.rd && reg_req.addr < CPG_ADDR_PAGE |=> reg_rdata == 8'h00)
        else $error("unmapped read not zero");
    a_reset_clear: assert property ($rose(reset_n) |-> !tx_valid && reg_rdata == 8'h00)
        else $error("outputs not cleared by reset");
endmodule : cpg_generator_sva
bind cpg_generator cpg_generator_sva cpg_generator_sva_inst (.clock(clock), .reset_n(reset_n), .reg_req(reg_req),
    .reg_rdata(reg_rdata), .selftest_active(selftest_active), .selftest_output_gating(selftest_output_gating),
    .tx_data(tx_data), .tx_valid(tx_valid), .tx_ready(tx_ready), .lanes_idle_lp11(lanes_idle_lp11),
    .lanes_disabled(lanes_disabled));
`default_nettype wire

// ==== cpg_rx_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module cpg_rx_model (
    input  wire logic             clock,
    input  wire logic             reset_n,
    input  wire cpg_pkg::cpg_tx_t tx_data,
    input  wire logic             tx_valid,
    input  wire logic             stall,
    output logic                  tx_ready
);
    import cpg_pkg::*;
    cpg_tx_t got_q[$];
    int      hdr_t[$];
    int      cyc = 0;
    initial tx_ready = 1'b0;
    // ----------------------------------------
    // accept items, stall at random when asked
    // ----------------------------------------
    always @(posedge clock) begin
        cyc++;
        if (reset_n && tx_valid && tx_ready) begin
            got_q.push_back(tx_data);
            if (tx_data.kind == CPG_PKT_LONG_HEADER) hdr_t.push_back(cyc);
        end
        #1;
        tx_ready = reset_n && (!stall || $urandom_range(0, 1) == 1);
    end
endmodule : cpg_rx_model
`default_nettype wire

// ==== cpg_generator_test.sv ====
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, gt) begin n_checks++; if ((gt) !== (ex)) begin error_cnt++; \
    $display("MISMATCH %s expected %0h seen %0h", nm, ex, gt); end end
module cpg_generator_test;
    import cpg_pkg::*;
    logic         clock, reset_n, rate_400, selftest_active, stall, tx_valid, tx_ready, idle_lp11, lanes_off;
    logic [1:0]   gating;
    logic [7:0]   rdata;
    logic [7:0]   regv [32];
    cpg_reg_req_t req;
    cpg_tx_t      tx_data, e, g;
    cpg_tx_t      exp_q[$];
    int           error_cnt, n_checks, fixed, bcode, blen, bw, len, act, tot, per, back, front, did, k, t0, t1;
    cpg_generator cpg_generator_inst (.clock(clock), .reset_n(reset_n), .reg_req(req), .reg_rdata(rdata),
        .rate_400(rate_400), .selftest_active(selftest_active), .selftest_output_gating(gating),
        .tx_data(tx_data), .tx_valid(tx_valid), .tx_ready(tx_ready), .lanes_idle_lp11(idle_lp11),
        .lanes_disabled(lanes_off));
    cpg_rx_model cpg_rx_model_inst (.clock(clock), .reset_n(reset_n), .tx_data(tx_data), .tx_valid(tx_valid),
        .stall(stall), .tx_ready(tx_ready));
    initial begin
        clock = 1'b0;
        forever #10 clock = ~clock;
    end
    // ----------------------------------------
    // register access and reference model
    // ----------------------------------------
    task automatic bus(input logic w, input logic r, input logic [7:0] a, input logic [7:0] v);
        req = '{wr: w, rd: r, addr: a, wdata: v};
        @(posedge clock);
        #1;
        req = '0;
        @(posedge clock);
        #1;
    endtask : bus
    task automatic gen_wr(input logic [7:0] o, input logic [7:0] v);
        bus(1'b1, 1'b0, CPG_ADDR_OFFSET, o);
        bus(1'b1, 1'b0, CPG_ADDR_DATA, v);
    endtask : gen_wr
    task automatic gen_rd(input logic [7:0] o);
        bus(1'b1, 1'b0, CPG_ADDR_OFFSET, o);
        bus(1'b0, 1'b1, CPG_ADDR_DATA, 8'h00);
    endtask : gen_rd
    function automatic cpg_tx_t mk(cpg_kind_t kd, int i, int w, logic [7:0] b, logic l);
        return '{kind: kd, data_id: 8'(i), word_count: 16'(w), data: b, last: l};
    endfunction : mk
    function automatic logic [7:0] exp_byte(int i);
        int b;
        b = (bw == 0) ? 0 : i / bw;
        if (b > (1 << bcode) - 1) b = (1 << bcode) - 1;
        if (fixed == 0) return CPG_BAR_VALUES[8 * b +: 8];
        return (b % 2 == 1) ? ~regv[16 + i % blen] : regv[16 + i % blen];
    endfunction : exp_byte
    task automatic run_frame(output int gap);
        int n;
        int v [14];
        v = '{(blen - 1) * 16 + fixed * 8 + bcode, did, len / 256, len, bw / 256, bw, act / 256, act,
              tot / 256, tot, per / 256, per, back, front};
        for (n = 0; n < 14; n++) gen_wr(8'(n + 2), 8'(v[n]));
        exp_q = {};
        cpg_rx_model_inst.got_q = {};
        cpg_rx_model_inst.hdr_t = {};
        exp_q.push_back(mk(CPG_PKT_FRAME_START, 0, 0, 8'h00, 1'b0));
        for (int ln = 0; ln < tot; ln++) begin
            if (ln >= back && ln < back + act) begin
                exp_q.push_back(mk(CPG_PKT_LONG_HEADER, did, len, 8'h00, 1'b0));
                for (n = 0; n < len; n++) exp_q.push_back(mk(CPG_PKT_PAYLOAD, 0, 0, exp_byte(n), n == len - 1));
            end else if (ln == back + act + front) begin
                exp_q.push_back(mk(CPG_PKT_FRAME_END, 0, 0, 8'h00, 1'b0));
            end
        end
        gen_wr(CPG_OFF_CONTROL, 8'h01);
        gen_wr(CPG_OFF_CONTROL, 8'h00);
        for (n = 0; n < 50000 && cpg_rx_model_inst.got_q.size() < exp_q.size(); n++) @(posedge clock);
        repeat (tot * per) @(posedge clock);
        #1;
        `CHK("item count", exp_q.size(), cpg_rx_model_inst.got_q.size())
        for (n = 0; n < exp_q.size() && n < cpg_rx_model_inst.got_q.size(); n++) begin
            e = exp_q[n];
            g = cpg_rx_model_inst.got_q[n];
            `CHK("kind", e.kind, g.kind)
            if (e.kind == CPG_PKT_LONG_HEADER) begin
                `CHK("data id", e.data_id, g.data_id)
                `CHK("word count", e.word_count, g.word_count)
            end else if (e.kind == CPG_PKT_PAYLOAD) begin
                `CHK("byte", e.data, g.data)
                `CHK("last", e.last, g.last)
            end
        end
        gap = (cpg_rx_model_inst.hdr_t.size() > 1) ? cpg_rx_model_inst.hdr_t[1] - cpg_rx_model_inst.hdr_t[0] : 0;
    endtask : run_frame
    task automatic print_verdict;
        $display("checks %0d mismatches %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : print_verdict
    // ----------------------------------------
    // tests
    // ----------------------------------------
    initial begin
        #2_000_000;
        error_cnt++;
        print_verdict();
    end
    initial begin
        req = '0;
        {rate_400, selftest_active, stall, gating, reset_n, error_cnt, n_checks} = '0;
        k = $urandom(56);
        repeat (6) @(posedge clock);
        #1;
        reset_n = 1'b1;
        @(posedge clock);
        #1;
        bus(1'b1, 1'b0, CPG_ADDR_PAGE, CPG_PAGE_GEN);
        for (k = 1; k < CPG_NUM_REGS; k++) begin
            gen_rd(8'(k));
            `CHK("reset value", CPG_REG_RESET, rdata)
            regv[k] = 8'($urandom);
            if (k > 1) gen_wr(8'(k), regv[k]);
        end
        for (k = 2; k < CPG_NUM_REGS; k++) begin
            gen_rd(8'(k));
            `CHK("readback", regv[k], rdata)
        end
        bus(1'b1, 1'b0, CPG_ADDR_PAGE, 8'h01);
        gen_wr(CPG_OFF_CONFIG, ~regv[2]);
        gen_rd(CPG_OFF_CONFIG);
        `CHK("other page", 8'h00, rdata)
        bus(1'b1, 1'b0, CPG_ADDR_PAGE, CPG_PAGE_GEN);
        gen_rd(CPG_OFF_CONFIG);
        `CHK("write ignored", regv[2], rdata)
        gen_rd(8'h21);
        `CHK("beyond map", 8'h00, rdata)
        bus(1'b0, 1'b1, 8'h33, 8'h00);
        `CHK("unmapped", 8'h00, rdata)
        $display("test registers done");
        {fixed, blen, back, act, front, tot, len, per} = {32'd0, 32'd1, 32'd1, 32'd1, 32'd1, 32'd4, 32'd57, 32'd342};
        bw = (len / 3 / 8) * 3;
        for (bcode = 0; bcode < 4; bcode++) begin
            stall = bcode[0];
            did = $urandom_range(0, 255);
            run_frame(t0);
        end
        $display("test color bars done");
        {fixed, bcode, stall} = {32'd1, 32'd2, 1'b1};
        for (k = 0; k < 3; k++) begin
            blen = (k == 0) ? CPG_BLOCK_BYTES : $urandom_range(1, 15);
            bw = 2 * blen;
            len = 4 * bw + blen;
            per = 6 * len + 24;
            run_frame(t0);
        end
        $display("test fixed color done");
        {fixed, bcode, stall, act, tot, bw, len, per} = {32'd0, 32'd3, 1'b0, 32'd2, 32'd5, 32'd2, 32'd19, 32'd120};
        run_frame(t0);
        rate_400 = 1'b1;
        run_frame(t1);
        `CHK("fast period", per / 2, t0)
        `CHK("line period", per / 2, t1 - t0)
        rate_400 = 1'b0;
        $display("test line period done");
        for (k = 0; k < 8; k++) begin
            {selftest_active, gating} = 3'(k);
            @(posedge clock);
            #1;
            `CHK("lp11 idle", k[2] && k[1:0] == 2'b10, idle_lp11)
            `CHK("lanes off", k[2] && k[1:0] != 2'b10, lanes_off)
        end
        gating = 2'b10;
        gen_wr(CPG_OFF_CONTROL, 8'h01);
        `CHK("video on lanes", 1'b0, idle_lp11)
        gen_wr(CPG_OFF_CONTROL, 8'h00);
        `CHK("lanes idle again", 1'b1, idle_lp11)
        $display("test self-test gating done");
        print_verdict();
    end
endmodule : cpg_generator_test
`default_nettype wire
